//--- acf_pkg.sv
// Constants and types for the flush, format and identify command block
package acf_pkg;

  // Register byte offsets
  localparam logic [7:0] ACF_OFS_CMD  = 8'h00;
  localparam logic [7:0] ACF_OFS_DH   = 8'h04;
  localparam logic [7:0] ACF_OFS_CH   = 8'h08;
  localparam logic [7:0] ACF_OFS_CL   = 8'h0c;
  localparam logic [7:0] ACF_OFS_SN   = 8'h10;
  localparam logic [7:0] ACF_OFS_SC   = 8'h14;
  localparam logic [7:0] ACF_OFS_FE   = 8'h18;
  localparam logic [7:0] ACF_OFS_STS  = 8'h1c;
  localparam logic [7:0] ACF_OFS_ERR  = 8'h20;
  localparam logic [7:0] ACF_OFS_DATA = 8'h24;
  localparam logic [7:0] ACF_OFS_ISTS = 8'h28;
  localparam logic [7:0] ACF_OFS_IMSK = 8'h2c;
  localparam logic [7:0] ACF_OFS_CFG  = 8'h30;

  // Command codes
  localparam logic [7:0] ACF_CMD_FLUSH  = 8'he7;
  localparam logic [7:0] ACF_CMD_FORMAT = 8'h50;
  localparam logic [7:0] ACF_CMD_IDENT  = 8'hec;

  // Drive/head field positions
  localparam int ACF_DH_LBA = 6;
  localparam int ACF_DH_DRV = 4;

  // Status and error values
  localparam logic [7:0] ACF_STS_READY = 8'h50;
  localparam logic [7:0] ACF_STS_BUSY  = 8'h80;
  localparam logic [7:0] ACF_STS_DRQ   = 8'h58;
  localparam logic [7:0] ACF_STS_ABORT = 8'h51;
  localparam logic [7:0] ACF_ERR_NONE  = 8'h00;
  localparam logic [7:0] ACF_ERR_ABRT  = 8'h04;

  // Interrupt events
  localparam int ACF_EV_DONE  = 0;
  localparam int ACF_EV_ABORT = 1;
  localparam int ACF_EV_DRQ   = 2;
  localparam int ACF_EV_W     = 3;
  localparam logic [2:0] ACF_IMSK_RST = 3'h0;

  // Configuration
  localparam int   ACF_CFG_FLUSH_EN  = 0;
  localparam logic ACF_CFG_FLUSH_RST = 1'b1;

  // Data block and fill
  localparam logic [7:0] ACF_LAST_WORD    = 8'hff;
  localparam logic [8:0] ACF_SECS_MAX     = 9'd256;
  localparam logic [7:0] ACF_FILL_PATTERN = 8'hff;
  localparam logic [7:0] ACF_LBA_FIRST    = 8'h00;
  localparam logic [7:0] ACF_CHS_FIRST    = 8'h01;

  // Identify word indices and fixed values
  localparam logic [7:0]  ACF_IDW_CONFIG = 8'd0;
  localparam logic [7:0]  ACF_IDW_CYLS   = 8'd1;
  localparam logic [7:0]  ACF_IDW_HEADS  = 8'd3;
  localparam logic [7:0]  ACF_IDW_SPT    = 8'd6;
  localparam logic [7:0]  ACF_IDW_LBA_LO = 8'd60;
  localparam logic [7:0]  ACF_IDW_LBA_HI = 8'd61;
  localparam logic [15:0] ACF_ID_CONFIG  = 16'h045a;

  typedef enum logic [2:0] {
    ACF_IDLE, ACF_FLUSH, ACF_FMT_DATA, ACF_FMT_FILL, ACF_ID_DATA
  } acf_state_t;

  function automatic logic [8:0] acf_sec_count(input logic [7:0] sc);
    return (sc == 8'h00) ? ACF_SECS_MAX : {1'b0, sc};
  endfunction : acf_sec_count

endpackage : acf_pkg

//--- acf_ident.sv
// Identify parameter block word lookup
`timescale 1ns/10ps
module acf_ident
  import acf_pkg::*;
#(
  parameter logic [15:0] CYLS  = 16'd1024,
  parameter logic [7:0]  HEADS = 8'd16,
  parameter logic [7:0]  SPT   = 8'd63
) (
  input  wire logic [7:0]  idx,
  output logic      [15:0] word
);
  localparam logic [31:0] TOTAL = 32'(CYLS) * 32'(HEADS) * 32'(SPT);

  // Unlisted words, reserved ones among them, read as zero
  always_comb begin
    case (idx)
      ACF_IDW_CONFIG: word = ACF_ID_CONFIG;
      ACF_IDW_CYLS:   word = CYLS;
      ACF_IDW_HEADS:  word = {8'h00, HEADS};
      ACF_IDW_SPT:    word = {8'h00, SPT};
      ACF_IDW_LBA_LO: word = TOTAL[15:0];
      ACF_IDW_LBA_HI: word = TOTAL[31:16];
      default:        word = 16'h0000;
    endcase
  end
endmodule : acf_ident

//--- acf_fill.sv
// Media fill sequencer for track formatting
`timescale 1ns/10ps
module acf_fill
  import acf_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        start,
  input  wire logic        lba_mode,
  input  wire logic [27:0] start_addr,
  input  wire logic [8:0]  count,
  output logic             media_valid,
  input  wire logic        media_ready,
  output logic             media_lba_mode,
  output logic      [27:0] media_addr,
  output logic      [7:0]  media_data,
  output logic             done
);
  typedef struct packed {
    logic        busy;
    logic        lba;
    logic [27:0] addr;
    logic [8:0]  left;
    logic        done;
  } acf_fill_t;

  acf_fill_t f_q, f_d;

  always_comb begin
    f_d = f_q;
    f_d.done = 1'b0;
    if (start) begin
      f_d.busy = 1'b1;
      f_d.lba  = lba_mode;
      f_d.addr = start_addr;
      f_d.left = count;
    end else if (f_q.busy && media_ready) begin
      // CHS walks the sector field only; head and cylinder stay put
      f_d.addr = f_q.lba ? f_q.addr + 28'd1 : {f_q.addr[27:8], f_q.addr[7:0] + 8'd1};
      f_d.left = f_q.left - 9'd1;
      if (f_q.left == 9'd1) begin
        f_d.busy = 1'b0;
        f_d.done = 1'b1;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      f_q <= '0;
    end else begin
      f_q <= f_d;
    end
  end

  assign media_valid    = f_q.busy;
  assign media_lba_mode = f_q.lba;
  assign media_addr     = f_q.addr;
  assign media_data     = ACF_FILL_PATTERN;
  assign done           = f_q.done;
endmodule : acf_fill

//--- acf_top.sv
// Flush cache, format track and identify device command interpreter
// Operation
// - Flush cache waits for the media to take every cached write before the command ends.
// - A finished flush shows status with ready and seek-complete set, only after the media is done.
// - With flush support off, the flush command is aborted instead of run.
// - Format track writes a constant fill pattern over the addressed track of the selected drive.
// - Format track takes one sector of host data-out words and throws them away.
// - In logical mode the sector count register gives the number of sectors, zero meaning 256.
// - Drive/head bit 6 selects logical mode, bit 4 the drive, the low nibble head or address bits 27 to 24.
// - Cylinder high and low give cylinder bytes or logical address bits 23 to 16 and 15 to 8.
// - Identify returns the parameter block with the single-sector data-in handshake.
// - Reserved bits and words of the parameter block read as zero.
// - Flush and identify look only at the drive bit and ignore the other parameter registers.
`timescale 1ns/10ps
module acf_top
  import acf_pkg::*;
#(
  parameter logic [15:0] CYLS  = 16'd1024,
  parameter logic [7:0]  HEADS = 8'd16,
  parameter logic [7:0]  SPT   = 8'd63
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic      [31:0] hrdata,
  input  wire logic        drive_id_pin,
  output logic             cache_flush_req,
  input  wire logic        cache_flush_done,
  output logic             media_valid,
  input  wire logic        media_ready,
  output logic             media_lba_mode,
  output logic      [27:0] media_addr,
  output logic      [7:0]  media_data,
  output logic             irq
);
  typedef struct packed {
    acf_state_t  st;
    logic [7:0]  dh;
    logic [7:0]  ch;
    logic [7:0]  cl;
    logic [7:0]  sn;
    logic [7:0]  sc;
    logic [7:0]  fe;
    logic [7:0]  sts;
    logic [7:0]  err;
    logic        flush_en;
    logic [2:0]  isr;
    logic [2:0]  imr;
    logic        irq;
    logic [7:0]  idx;
    logic        wr_pend;
    logic        rd_ph;
    logic [7:0]  addr;
    logic [31:0] rdata;
    logic        flush_req;
    logic        fill_go;
    logic        sync1;
    logic        sync2;
  } acf_regs_t;

  acf_regs_t              s_q, s_d;
  logic                   acc;
  logic                   cmd_wr;
  logic                   data_wr;
  logic      [7:0]        cmd_code;
  logic      [15:0]       ident_word;
  logic                   fill_done;
  logic      [8:0]        fill_count;
  logic      [27:0]       fill_addr;
  logic [ACF_EV_W-1:0]    ev;

  assign acc      = hsel && hready && htrans[1];
  assign cmd_code = hwdata[7:0];
  // Only the drive bit and the idle state qualify a command; other task-file bytes are not looked at here
  assign cmd_wr   = s_q.wr_pend && s_q.addr == ACF_OFS_CMD && s_q.st == ACF_IDLE
                    && s_q.dh[ACF_DH_DRV] == s_q.sync2;
  assign data_wr  = s_q.wr_pend && s_q.addr == ACF_OFS_DATA;

  // Start address: head or LBA[27:24], cylinder bytes or LBA[23:8]
  assign fill_addr  = {s_q.dh[3:0], s_q.ch, s_q.cl,
                       s_q.dh[ACF_DH_LBA] ? ACF_LBA_FIRST : ACF_CHS_FIRST};
  assign fill_count = s_q.dh[ACF_DH_LBA] ? acf_sec_count(s_q.sc) : {1'b0, SPT};

  always_comb begin
    s_d         = s_q;
    ev          = '0;
    s_d.sync1   = drive_id_pin;
    s_d.sync2   = s_q.sync1;
    s_d.fill_go = 1'b0;
    s_d.rd_ph   = 1'b0;
    s_d.wr_pend = 1'b0;
    if (acc) begin
      s_d.addr    = haddr[7:0];
      s_d.wr_pend = hwrite;
      s_d.rd_ph   = ~hwrite;
    end
    // Reads take one wait state so a write just before is already stored
    if (s_q.rd_ph) begin
      s_d.rdata = '0;
      case (s_q.addr)
        ACF_OFS_DH:   s_d.rdata = {24'h0, s_q.dh};
        ACF_OFS_CH:   s_d.rdata = {24'h0, s_q.ch};
        ACF_OFS_CL:   s_d.rdata = {24'h0, s_q.cl};
        ACF_OFS_SN:   s_d.rdata = {24'h0, s_q.sn};
        ACF_OFS_SC:   s_d.rdata = {24'h0, s_q.sc};
        ACF_OFS_STS:  s_d.rdata = {24'h0, s_q.sts};
        ACF_OFS_ERR:  s_d.rdata = {24'h0, s_q.err};
        ACF_OFS_ISTS: s_d.rdata = {29'h0, s_q.isr};
        ACF_OFS_IMSK: s_d.rdata = {29'h0, s_q.imr};
        ACF_OFS_CFG:  s_d.rdata = {31'h0, s_q.flush_en};
        ACF_OFS_DATA: begin
          if (s_q.st == ACF_ID_DATA) begin
            s_d.rdata = {16'h0, ident_word};
            s_d.idx   = s_q.idx + 8'd1;
            if (s_q.idx == ACF_LAST_WORD) begin
              s_d.st  = ACF_IDLE;
              s_d.sts = ACF_STS_READY;
              ev[ACF_EV_DONE] = 1'b1;
            end
          end
        end
        default:      s_d.rdata = '0;
      endcase
    end
    if (s_q.wr_pend) begin
      case (s_q.addr)
        ACF_OFS_DH:   s_d.dh = hwdata[7:0];
        ACF_OFS_CH:   s_d.ch = hwdata[7:0];
        ACF_OFS_CL:   s_d.cl = hwdata[7:0];
        ACF_OFS_SN:   s_d.sn = hwdata[7:0];
        ACF_OFS_SC:   s_d.sc = hwdata[7:0];
        ACF_OFS_FE:   s_d.fe = hwdata[7:0];
        ACF_OFS_ISTS: s_d.isr = s_q.isr & ~hwdata[ACF_EV_W-1:0];
        ACF_OFS_IMSK: s_d.imr = hwdata[ACF_EV_W-1:0];
        ACF_OFS_CFG:  s_d.flush_en = hwdata[ACF_CFG_FLUSH_EN];
        default: begin
        end
      endcase
    end
    if (cmd_wr) begin
      s_d.err = ACF_ERR_NONE;
      case (cmd_code)
        ACF_CMD_FLUSH: begin
          if (s_q.flush_en) begin
            s_d.st        = ACF_FLUSH;
            s_d.sts       = ACF_STS_BUSY;
            s_d.flush_req = 1'b1;
          end else begin
            s_d.sts = ACF_STS_ABORT;
            s_d.err = ACF_ERR_ABRT;
            ev[ACF_EV_ABORT] = 1'b1;
          end
        end
        ACF_CMD_FORMAT: begin
          // Accepted for old hosts; new ones should not send it
          s_d.st  = ACF_FMT_DATA;
          s_d.sts = ACF_STS_DRQ;
          s_d.idx = 8'h00;
          ev[ACF_EV_DRQ] = 1'b1;
        end
        ACF_CMD_IDENT: begin
          s_d.st  = ACF_ID_DATA;
          s_d.sts = ACF_STS_DRQ;
          s_d.idx = 8'h00;
          ev[ACF_EV_DRQ] = 1'b1;
        end
        default: begin
          s_d.sts = ACF_STS_ABORT;
          s_d.err = ACF_ERR_ABRT;
          ev[ACF_EV_ABORT] = 1'b1;
        end
      endcase
    end
    // Host data-out words are counted, never stored
    if (data_wr && s_q.st == ACF_FMT_DATA) begin
      s_d.idx = s_q.idx + 8'd1;
      if (s_q.idx == ACF_LAST_WORD) begin
        s_d.st      = ACF_FMT_FILL;
        s_d.sts     = ACF_STS_BUSY;
        s_d.fill_go = 1'b1;
      end
    end
    case (s_q.st)
      ACF_FLUSH: begin
        if (cache_flush_done) begin
          s_d.flush_req = 1'b0;
          s_d.st        = ACF_IDLE;
          s_d.sts       = ACF_STS_READY;
          ev[ACF_EV_DONE] = 1'b1;
        end
      end
      ACF_FMT_FILL: begin
        if (fill_done) begin
          s_d.st  = ACF_IDLE;
          s_d.sts = ACF_STS_READY;
          ev[ACF_EV_DONE] = 1'b1;
        end
      end
      default: begin
      end
    endcase
    // A new event outweighs a clear in the same cycle
    s_d.isr = s_d.isr | ev;
    s_d.irq = |(s_d.isr & s_d.imr);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_q          <= '0;
      s_q.st       <= ACF_IDLE;
      s_q.sts      <= ACF_STS_READY;
      s_q.err      <= ACF_ERR_NONE;
      s_q.imr      <= ACF_IMSK_RST;
      s_q.flush_en <= ACF_CFG_FLUSH_RST;
    end else begin
      s_q <= s_d;
    end
  end

  acf_ident #(
    .CYLS  (CYLS),
    .HEADS (HEADS),
    .SPT   (SPT)
  ) u_ident (
    .idx  (s_q.idx),
    .word (ident_word)
  );

  acf_fill u_fill (
    .hclk           (hclk),
    .hresetn        (hresetn),
    .start          (s_q.fill_go),
    .lba_mode       (s_q.dh[ACF_DH_LBA]),
    .start_addr     (fill_addr),
    .count          (fill_count),
    .media_valid    (media_valid),
    .media_ready    (media_ready),
    .media_lba_mode (media_lba_mode),
    .media_addr     (media_addr),
    .media_data     (media_data),
    .done           (fill_done)
  );

  assign hreadyout       = ~s_q.rd_ph;
  assign hresp           = 1'b0;
  assign hrdata          = s_q.rdata;
  assign cache_flush_req = s_q.flush_req;
  assign irq             = s_q.irq;

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  a_flush_waits_media: assert property (
    s_q.st == ACF_FLUSH && !cache_flush_done |=> s_q.st == ACF_FLUSH && cache_flush_req)
    else $error("flush ended before media done");

  a_flush_done_status: assert property (
    s_q.st == ACF_FLUSH && cache_flush_done |=> s_q.sts == ACF_STS_READY && s_q.isr[ACF_EV_DONE])
    else $error("flush completion status wrong");

  a_flush_off_abort: assert property (
    cmd_wr && cmd_code == ACF_CMD_FLUSH && !s_q.flush_en
    |=> s_q.st == ACF_IDLE && s_q.err == ACF_ERR_ABRT && !cache_flush_req)
    else $error("unsupported flush not aborted");

  a_fill_only_format: assert property (
    media_valid |-> s_q.st == ACF_FMT_FILL && media_data == ACF_FILL_PATTERN)
    else $error("media fill outside format");

  a_format_data_end: assert property (
    data_wr && s_q.st == ACF_FMT_DATA && s_q.idx == ACF_LAST_WORD
    |=> s_q.st == ACF_FMT_FILL && s_q.fill_go ##1 media_valid)
    else $error("format data block did not start fill");

  a_lba_zero_count: assert property (
    s_q.fill_go && s_q.dh[ACF_DH_LBA] && s_q.sc == 8'h00 |-> fill_count == 9'd256)
    else $error("zero sector count not 256");

  a_busy_while_run: assert property (
    s_q.st == ACF_FLUSH || s_q.st == ACF_FMT_FILL |-> s_q.sts == ACF_STS_BUSY)
    else $error("busy not set while running");

  a_done_raises_irq: assert property (
    s_q.st != ACF_IDLE ##1 s_q.st == ACF_IDLE |-> s_q.isr[ACF_EV_DONE] && !s_q.sts[7])
    else $error("completion without interrupt");

  a_ident_enter: assert property (
    cmd_wr && cmd_code == ACF_CMD_IDENT |=> s_q.st == ACF_ID_DATA && s_q.sts == ACF_STS_DRQ)
    else $error("identify did not request data-in");

  a_ident_reserved: assert property (
    s_q.st == ACF_ID_DATA && s_q.idx == 8'd2 |-> ident_word == 16'h0000)
    else $error("reserved identify word not zero");

  a_other_drive_ignored: assert property (
    s_q.wr_pend && s_q.addr == ACF_OFS_CMD && s_q.st == ACF_IDLE && s_q.dh[ACF_DH_DRV] != s_q.sync2
    |=> $stable(s_q.sts) && s_q.st == ACF_IDLE)
    else $error("command for other drive taken");

  c_flush_done:  cover property (s_q.st == ACF_FLUSH ##1 s_q.st == ACF_IDLE);
  c_ident_done:  cover property (s_q.st == ACF_ID_DATA ##1 s_q.st == ACF_IDLE);
  c_format_done: cover property (s_q.st == ACF_FMT_FILL ##1 s_q.st == ACF_IDLE);
  c_abort:       cover property (cmd_wr ##1 s_q.err == ACF_ERR_ABRT);
endmodule : acf_top

//--- acf_far_model.sv
// Cache and media model standing on the far side of the command block
`timescale 1ns/10ps
module acf_far_model #(
  parameter int FLUSH_LAT = 6
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        clr,
  input  wire logic        cache_flush_req,
  output logic             cache_flush_done,
  input  wire logic        media_valid,
  output logic             media_ready,
  input  wire logic        media_lba_mode,
  input  wire logic [27:0] media_addr,
  input  wire logic [7:0]  media_data,
  output int               fills,
  output logic      [27:0] first_addr,
  output logic             first_lba,
  output logic      [7:0]  last_data
);
  int lat_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lat_q            <= 0;
      cache_flush_done <= 1'b0;
      media_ready      <= 1'b0;
      fills            <= 0;
      first_addr       <= 28'h0;
      first_lba        <= 1'b0;
      last_data        <= 8'h00;
    end else begin
      // Commit takes time, so a block that ends early is caught
      lat_q            <= cache_flush_req ? lat_q + 1 : 0;
      cache_flush_done <= cache_flush_req && (lat_q == FLUSH_LAT);
      // Stall every other cycle to exercise the fill handshake
      media_ready      <= ~media_ready;
      if (clr) begin
        fills <= 0;
      end else if (media_valid && media_ready) begin
        if (fills == 0) begin
          first_addr <= media_addr;
          first_lba  <= media_lba_mode;
        end
        fills     <= fills + 1;
        last_data <= media_data;
      end
    end
  end
endmodule : acf_far_model

//--- tb_top.sv
// Self-checking bench for the flush, format and identify block
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin errors++; \
  $display("wrong value %s expected %h seen %h", nm, ex, got); end end
module tb_top;
  import acf_pkg::*;
  logic        hclk, hresetn, hsel, hwrite, clr, drive_id;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans;
  logic        hreadyout, hresp, cache_flush_req, cache_flush_done;
  logic        media_valid, media_ready, media_lba_mode, irq, first_lba;
  logic [27:0] media_addr, first_addr;
  logic [7:0]  media_data, last_data;
  int          fills, errors, n_checks, cyc;

  acf_top uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .drive_id_pin(drive_id), .cache_flush_req(cache_flush_req),
    .cache_flush_done(cache_flush_done), .media_valid(media_valid), .media_ready(media_ready),
    .media_lba_mode(media_lba_mode), .media_addr(media_addr), .media_data(media_data), .irq(irq));

  acf_far_model far (.hclk(hclk), .hresetn(hresetn), .clr(clr), .cache_flush_req(cache_flush_req),
    .cache_flush_done(cache_flush_done), .media_valid(media_valid), .media_ready(media_ready),
    .media_lba_mode(media_lba_mode), .media_addr(media_addr), .media_data(media_data),
    .fills(fills), .first_addr(first_addr), .first_lba(first_lba), .last_data(last_data));

  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end

  task automatic give_verdict;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : give_verdict

  // Ceiling well above the longest sequence of scenarios
  always @(posedge hclk) begin
    cyc++;
    if (cyc > 40000) begin
      errors++;
      give_verdict();
    end
  end

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    htrans <= 2'b10;
    haddr  <= {24'h0, a};
    hwrite <= 1'b1;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
  endtask : wr

  task automatic rdw(input logic [7:0] a);
    htrans <= 2'b10;
    haddr  <= {24'h0, a};
    hwrite <= 1'b0;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : rdw

  task automatic wait_ready;
    int n;
    n = 0;
    do begin
      rdw(ACF_OFS_STS);
      n++;
    end while (rd[7:0] !== ACF_STS_READY && n < 3000);
  endtask : wait_ready

  task automatic t_regs;
    rdw(ACF_OFS_STS);  `CHK("status reset", ACF_STS_READY, rd[7:0])
    rdw(ACF_OFS_ERR);  `CHK("error reset", ACF_ERR_NONE, rd[7:0])
    wr(ACF_OFS_CL, 32'h5a);
    rdw(ACF_OFS_CL);   `CHK("cyl low rw", 8'h5a, rd[7:0])
    wr(ACF_OFS_FE, 32'h33);
    rdw(ACF_OFS_FE);   `CHK("features wo", 32'h0, rd)
    rdw(8'hfc);        `CHK("unmapped", 32'h0, rd)
    `CHK("bus response", 1'b0, hresp)
  endtask : t_regs

  task automatic t_flush;
    wr(ACF_OFS_IMSK, 32'h1);
    wr(ACF_OFS_FE, 32'hff);
    wr(ACF_OFS_DH, 32'hef);
    wr(ACF_OFS_CMD, {24'h0, ACF_CMD_FLUSH});
    rdw(ACF_OFS_STS);  `CHK("flush busy", ACF_STS_BUSY, rd[7:0])
    `CHK("flush req", 1'b1, cache_flush_req)
    `CHK("irq in busy", 1'b0, irq)
    wait_ready();      `CHK("flush status", ACF_STS_READY, rd[7:0])
    `CHK("req dropped", 1'b0, cache_flush_req)
    `CHK("flush irq", 1'b1, irq)
    rdw(ACF_OFS_ISTS); `CHK("isr done", 3'h1, rd[2:0])
    wr(ACF_OFS_ISTS, 32'h1);
    rdw(ACF_OFS_ISTS); `CHK("isr cleared", 3'h0, rd[2:0])
    `CHK("irq cleared", 1'b0, irq)
    wr(ACF_OFS_DH, 32'h10);
    wr(ACF_OFS_CMD, {24'h0, ACF_CMD_FLUSH});
    rdw(ACF_OFS_STS);  `CHK("other drive", ACF_STS_READY, rd[7:0])
    // Strap moved to drive one: the same command now belongs to this device
    drive_id <= 1'b1;
    repeat (3) @(posedge hclk);
    wr(ACF_OFS_CMD, {24'h0, ACF_CMD_FLUSH});
    rdw(ACF_OFS_STS);  `CHK("drive one busy", ACF_STS_BUSY, rd[7:0])
    wait_ready();      `CHK("drive one done", ACF_STS_READY, rd[7:0])
    wr(ACF_OFS_ISTS, 32'h1);
    drive_id <= 1'b0;
  endtask : t_flush

  task automatic t_abort;
    wr(ACF_OFS_CFG, 32'h0);
    wr(ACF_OFS_DH, 32'h00);
    wr(ACF_OFS_CMD, {24'h0, ACF_CMD_FLUSH});
    rdw(ACF_OFS_STS);  `CHK("abort status", ACF_STS_ABORT, rd[7:0])
    rdw(ACF_OFS_ERR);  `CHK("abort error", ACF_ERR_ABRT, rd[7:0])
    rdw(ACF_OFS_ISTS); `CHK("isr abort", 3'h2, rd[2:0])
    `CHK("masked irq", 1'b0, irq)
    `CHK("no req", 1'b0, cache_flush_req)
    wr(ACF_OFS_ISTS, 32'h7);
    wr(ACF_OFS_CFG, 32'h1);
    // A code this block does not know is refused the same way
    wr(ACF_OFS_CMD, 32'h00);
    rdw(ACF_OFS_STS);  `CHK("unknown code", ACF_STS_ABORT, rd[7:0])
    rdw(ACF_OFS_ISTS); `CHK("isr unknown", 3'h2, rd[2:0])
    wr(ACF_OFS_ISTS, 32'h7);
  endtask : t_abort

  task automatic t_format(input logic [7:0] dh, input logic [7:0] sc, input int n, input logic [27:0] a);
    clr <= 1'b1;
    wr(ACF_OFS_DH, {24'h0, dh});
    clr <= 1'b0;
    wr(ACF_OFS_CH, 32'h12);
    wr(ACF_OFS_CL, 32'h34);
    wr(ACF_OFS_SC, {24'h0, sc});
    wr(ACF_OFS_CMD, {24'h0, ACF_CMD_FORMAT});
    rdw(ACF_OFS_STS);  `CHK("format drq", ACF_STS_DRQ, rd[7:0])
    rdw(ACF_OFS_ERR);  `CHK("error cleared", ACF_ERR_NONE, rd[7:0])
    // One whole sector of host words, contents meaningless
    for (int i = 0; i < 256; i++) wr(ACF_OFS_DATA, 32'h0000a5a5 ^ i);
    wait_ready();      `CHK("format status", ACF_STS_READY, rd[7:0])
    `CHK("fill count", n, fills)
    `CHK("fill addr", a, first_addr)
    `CHK("fill mode", dh[6], first_lba)
    `CHK("fill data", ACF_FILL_PATTERN, last_data)
    wr(ACF_OFS_ISTS, 32'h7);
  endtask : t_format

  task automatic t_ident;
    logic [15:0] ex;
    wr(ACF_OFS_DH, 32'h4f);
    wr(ACF_OFS_CMD, {24'h0, ACF_CMD_IDENT});
    rdw(ACF_OFS_STS);  `CHK("ident drq", ACF_STS_DRQ, rd[7:0])
    for (int i = 0; i < 256; i++) begin
      case (i)
        0:       ex = 16'h045a;
        1:       ex = 16'h0400;
        3:       ex = 16'h0010;
        6:       ex = 16'h003f;
        60:      ex = 16'hc000;
        61:      ex = 16'h000f;
        default: ex = 16'h0000;
      endcase
      rdw(ACF_OFS_DATA); `CHK("ident word", ex, rd[15:0])
    end
    rdw(ACF_OFS_STS);  `CHK("ident done", ACF_STS_READY, rd[7:0])
  endtask : t_ident

  initial begin
    hresetn = 1'b0;
    hsel = 1'b1;
    htrans = 2'b00;
    haddr = 32'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    clr = 1'b0;
    drive_id = 1'b0;
    errors = 0;
    n_checks = 0;
    cyc = 0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (3) @(posedge hclk);
    t_regs();
    t_flush();
    t_abort();
    t_format(8'h45, 8'h00, 256, 28'h5123400);
    t_format(8'h03, 8'h05, 63, 28'h3123401);
    t_ident();
    give_verdict();
  end
endmodule : tb_top
